// ==== src/pirpg_regs.sv ====
// Overview of operation
// - Select bit picks odd or even GPIO
// - Select bits read/write, reset to zero
// - Bit 29 enables doubled VCO clock, resets one
// - Divider modulo 9:7, pattern 6:5, reset zero
// - Charge-pump current field 3:2, reset zero
// - Bit 1 selects PLL reference, resets one
// - Bit 0 enables VCO overvoltage guard
// - Bandgap and ADC clock gates, reset enabled
// - DAC and comparator clock gates, reset enabled
module pirpg_regs #(
  parameter int unsigned ADDR_W    = 8,
  parameter int unsigned NUM_EXTRA = pirpg_pkg::NUM_EXTRA
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  // AXI4-Lite write address
  input  wire logic                   s_axi_awvalid,
  output      logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                   s_axi_wvalid,
  output      logic                   s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // AXI4-Lite write response
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output      logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                   s_axi_arvalid,
  output      logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  // AXI4-Lite read data
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  // Interrupt routing
  input  wire logic [2*NUM_EXTRA-1:0] gpio_i,
  output      logic [NUM_EXTRA-1:0]   extra_irq_o,
  // Synthesiser controls
  output      logic                   doubled_vco_output_on_o,
  output      logic [2:0]             out_div_modulo_o,
  output      logic [1:0]             out_div_pattern_o,
  output      logic [1:0]             charge_pump_current_o,
  output      logic                   ref_clock_select_o,
  output      logic                   vco_overvoltage_guard_o,
  // Analog clock gates
  output      logic                   bandgap_clock_gate_o,
  output      logic                   adc_clock_gate_o,
  output      logic                   dac_clock_gate_o,
  output      logic                   comparator_clock_gate_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       sel;
    logic [31:0]       pll;
    logic [31:0]       gates;
  } pirpg_state_t;

  pirpg_state_t state_q;
  pirpg_state_t state_d;

  logic              wr_fire;
  logic              wr_sel;
  logic              wr_pll;
  logic              wr_gates;
  logic              rd_fire;
  logic [ADDR_W-1:0] rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] bm;
    bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old_v & ~bm) | (new_v & bm)) & mask;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [7:0]        off);
    return {addr[ADDR_W-1:2], 2'b00} == ADDR_W'(off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  assign s_axi_awready = !state_q.aw_got && !state_q.bvalid;
  assign s_axi_wready  = !state_q.w_got && !state_q.bvalid;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_bvalid  = state_q.bvalid;
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = state_q.rdata;
  assign s_axi_rresp   = state_q.rresp;

  assign wr_fire  = state_q.aw_got && state_q.w_got && !state_q.bvalid;
  assign wr_sel   = wr_fire && hit(state_q.awaddr, pirpg_pkg::OFF_SEL);
  assign wr_pll   = wr_fire && hit(state_q.awaddr, pirpg_pkg::OFF_PLL);
  assign wr_gates = wr_fire && hit(state_q.awaddr, pirpg_pkg::OFF_GATES);
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign rd_addr  = s_axi_araddr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.aw_got = 1'b1;
      state_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.w_got = 1'b1;
      state_d.wdata = s_axi_wdata;
      state_d.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_d.aw_got = 1'b0;
      state_d.w_got  = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp  = pirpg_pkg::RESP_OKAY;
      if (wr_sel) begin
        state_d.sel = merge(state_q.sel, state_q.wdata, state_q.wstrb,
                            pirpg_pkg::SEL_MASK);
      end else if (wr_pll) begin
        state_d.pll = merge(state_q.pll, state_q.wdata, state_q.wstrb,
                            pirpg_pkg::PLL_MASK);
      end else if (wr_gates) begin
        state_d.gates = merge(state_q.gates, state_q.wdata, state_q.wstrb,
                              pirpg_pkg::GATES_MASK);
      end else begin
        state_d.bresp = pirpg_pkg::RESP_SLVERR;
      end
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    // Reads return the masked image, reserved bits as zero
    if (rd_fire) begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = pirpg_pkg::RESP_OKAY;
      if (hit(rd_addr, pirpg_pkg::OFF_SEL)) begin
        state_d.rdata = state_q.sel;
      end else if (hit(rd_addr, pirpg_pkg::OFF_PLL)) begin
        state_d.rdata = state_q.pll;
      end else if (hit(rd_addr, pirpg_pkg::OFF_GATES)) begin
        state_d.rdata = state_q.gates;
      end else begin
        state_d.rdata = 32'h0000_0000;
        state_d.rresp = pirpg_pkg::RESP_SLVERR;
      end
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q        <= '0;
      state_q.sel    <= pirpg_pkg::SEL_RESET;
      state_q.pll    <= pirpg_pkg::PLL_RESET;
      state_q.gates  <= pirpg_pkg::GATES_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field outputs

  assign doubled_vco_output_on_o =
    state_q.pll[pirpg_pkg::PLL_VCOX2_BIT];
  assign out_div_modulo_o =
    state_q.pll[pirpg_pkg::PLL_MOD_MSB:pirpg_pkg::PLL_MOD_LSB];
  assign out_div_pattern_o =
    state_q.pll[pirpg_pkg::PLL_PAT_MSB:pirpg_pkg::PLL_PAT_LSB];
  assign charge_pump_current_o =
    state_q.pll[pirpg_pkg::PLL_ICP_MSB:pirpg_pkg::PLL_ICP_LSB];
  assign ref_clock_select_o =
    state_q.pll[pirpg_pkg::PLL_REF_BIT];
  assign vco_overvoltage_guard_o =
    state_q.pll[pirpg_pkg::PLL_OVP_BIT];
  assign bandgap_clock_gate_o =
    state_q.gates[pirpg_pkg::GATE_BG_BIT];
  assign adc_clock_gate_o =
    state_q.gates[pirpg_pkg::GATE_ADC_BIT];
  assign dac_clock_gate_o =
    state_q.gates[pirpg_pkg::GATE_DAC_BIT];
  assign comparator_clock_gate_o =
    state_q.gates[pirpg_pkg::GATE_COMP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing

  pirpg_route_if #(.N(NUM_EXTRA)) route_bus ();

  assign route_bus.sel  = state_q.sel[NUM_EXTRA-1:0];
  assign route_bus.gpio = gpio_i;
  assign extra_irq_o    = route_bus.irq;

  pirpg_irq_route #(
    .N (NUM_EXTRA)
  ) pirpg_irq_route_inst (
    .bus (route_bus.route)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [NUM_EXTRA-1:0] irq_expect;

  always_comb begin
    for (int k = 0; k < int'(NUM_EXTRA); k++) begin
      irq_expect[k] = state_q.sel[k] ? gpio_i[2*k] : gpio_i[2*k+1];
    end
  end

  AST_ROUTE_PICK: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    extra_irq_o == irq_expect)
    else $error("extra interrupt routed from wrong GPIO");

  AST_SEL_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_sel && state_q.wstrb == 4'hf
    |=> state_q.sel == ($past(state_q.wdata) & pirpg_pkg::SEL_MASK))
    else $error("select register did not take written value");

  AST_VCOX2_CAUSE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    $changed(doubled_vco_output_on_o) |-> $past(wr_pll))
    else $error("doubled clock enable changed without a write");

  AST_DIV_FIELDS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_pll && state_q.wstrb[1:0] == 2'h3
    |=> out_div_modulo_o == $past(state_q.wdata[9:7])
        && out_div_pattern_o == $past(state_q.wdata[6:5]))
    else $error("divider fields not updated by write");

  AST_ICP_HOLD: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    !wr_pll |=> $stable(charge_pump_current_o))
    else $error("charge-pump field moved without a write");

  AST_REF_READ: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    rd_fire && hit(rd_addr, pirpg_pkg::OFF_PLL)
    |=> s_axi_rvalid && s_axi_rdata[1] == $past(ref_clock_select_o))
    else $error("reference select not visible on read");

  AST_OVP_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_pll && state_q.wstrb[0]
    |=> vco_overvoltage_guard_o == $past(state_q.wdata[0]))
    else $error("overvoltage guard not updated by write");

  AST_BG_ADC_OFF: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    $fell(bandgap_clock_gate_o) || $fell(adc_clock_gate_o)
    |-> $past(wr_gates && state_q.wstrb[0]))
    else $error("bandgap or ADC gate closed without a write");

  AST_DAC_COMP: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_gates && state_q.wstrb[0]
    |=> dac_clock_gate_o == $past(state_q.wdata[1])
        && comparator_clock_gate_o == $past(state_q.wdata[0]))
    else $error("DAC or comparator gate not updated by write");

  AST_VCOX2_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_pll && state_q.wstrb[3]
    |=> doubled_vco_output_on_o ==
        $past(state_q.wdata[pirpg_pkg::PLL_VCOX2_BIT]))
    else $error("doubled clock enable not updated by write");

  AST_ICP_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_pll && state_q.wstrb[0]
    |=> charge_pump_current_o == $past(state_q.wdata[3:2]))
    else $error("charge-pump field not updated by write");

  AST_REF_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_pll && state_q.wstrb[0]
    |=> ref_clock_select_o == $past(state_q.wdata[1]))
    else $error("reference select not updated by write");

  AST_BG_ADC_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_gates && state_q.wstrb[0]
    |=> bandgap_clock_gate_o == $past(state_q.wdata[4])
        && adc_clock_gate_o == $past(state_q.wdata[3]))
    else $error("bandgap or ADC gate not updated by write");

  AST_SEL_READ: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    rd_fire && hit(rd_addr, pirpg_pkg::OFF_SEL)
    |=> s_axi_rvalid && s_axi_rdata == $past(state_q.sel))
    else $error("select register not visible on read");

  AST_IRQ_STEADY: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    $stable(gpio_i) && $stable(state_q.sel) |-> $stable(extra_irq_o))
    else $error("extra interrupt moved with source and select steady");

  AST_ROUTE_SWITCH: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_sel && state_q.wstrb[0] && $stable(gpio_i[1:0])
    |=> extra_irq_o[0] ==
        ($past(state_q.wdata[0]) ? gpio_i[0] : gpio_i[1]))
    else $error("first extra interrupt did not switch source");

  AST_B_HOLD: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");

  AST_R_HOLD: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");

endmodule

// ==== src/pirpg_pkg.sv ====
package pirpg_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_SEL   = 8'ha8;
  localparam logic [7:0] OFF_PLL   = 8'hb0;
  localparam logic [7:0] OFF_GATES = 8'hb4;

  // Extra interrupt routing
  localparam int unsigned NUM_EXTRA   = 25;
  localparam int unsigned FIRST_EXTRA = 34;

  // Implemented bits and reset values
  localparam logic [31:0] SEL_MASK    = 32'h01ff_ffff;
  localparam logic [31:0] SEL_RESET   = 32'h0000_0000;
  localparam logic [31:0] PLL_MASK    = 32'h20ff_ffff;
  localparam logic [31:0] PLL_RESET   = 32'h2000_cc12;
  localparam logic [31:0] GATES_MASK  = 32'h0000_001b;
  localparam logic [31:0] GATES_RESET = 32'h0000_001b;

  // Synthesiser control field positions
  localparam int unsigned PLL_VCOX2_BIT = 29;
  localparam int unsigned PLL_MOD_MSB   = 9;
  localparam int unsigned PLL_MOD_LSB   = 7;
  localparam int unsigned PLL_PAT_MSB   = 6;
  localparam int unsigned PLL_PAT_LSB   = 5;
  localparam int unsigned PLL_ICP_MSB   = 3;
  localparam int unsigned PLL_ICP_LSB   = 2;
  localparam int unsigned PLL_REF_BIT   = 1;
  localparam int unsigned PLL_OVP_BIT   = 0;

  // Analog clock gate positions
  localparam int unsigned GATE_BG_BIT   = 4;
  localparam int unsigned GATE_ADC_BIT  = 3;
  localparam int unsigned GATE_DAC_BIT  = 1;
  localparam int unsigned GATE_COMP_BIT = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== src/pirpg_route_if.sv ====
interface pirpg_route_if #(
  parameter int unsigned N = 25
);
  logic [N-1:0]   sel;
  logic [2*N-1:0] gpio;
  logic [N-1:0]   irq;

  modport drive (output sel, output gpio, input irq);
  modport route (input sel, input gpio, output irq);
endinterface

// ==== src/pirpg_irq_route.sv ====
module pirpg_irq_route #(
  parameter int unsigned N = 25
) (
  // Routing carrier
  pirpg_route_if.route bus
);

  // Pure mux: no state, so a select write cannot add a pulse of its own
  for (genvar k = 0; k < N; k++) begin : g_route
    assign bus.irq[k] = bus.sel[k] ? bus.gpio[2*k] : bus.gpio[2*k+1];
  end

endmodule

// ==== tb/pmu_irq_route_pll_gate_regs_bench.sv ====
module pmu_irq_route_pll_gate_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock   = 1'b0;
  logic        reset_n = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready  = 1'b1;
  logic        rready  = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'h0;
  logic [49:0] gpio    = 50'h0_0000_0000_0000;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, pll_view, gate_view;
  logic [24:0] irq;
  logic [2:0]  modulo;
  logic [1:0]  pattern, icp;
  logic        vcox2, refsel, ovp, gbg, gadc, gdac, gcmp;
  logic        watch   = 1'b0;
  int          num_errors      = 0;
  int          samples_checked = 0;
  int          glitches        = 0;
  int          lag             = 0;
  logic [24:0] sels [4] = '{25'h1ff_ffff, 25'h155_5555, 25'h0aa_aaaa,
                            25'h000_0001};
  logic [39:0] regs [9] = '{{8'hb0, 32'h0000_03ed}, {8'hb0, 32'h2000_0148},
                            {8'hb0, 32'h20ff_ffff}, {8'hb4, 32'h0000_0000},
                            {8'hb4, 32'h0000_0010}, {8'hb4, 32'h0000_0008},
                            {8'hb4, 32'h0000_0002}, {8'hb4, 32'h0000_0001},
                            {8'hb4, 32'h0000_001b}};

  always #5 clock = ~clock;

  pirpg_regs pirpg_regs_inst (
    .clock_i(clock), .reset_n_i(reset_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .gpio_i(gpio), .extra_irq_o(irq),
    .doubled_vco_output_on_o(vcox2), .out_div_modulo_o(modulo),
    .out_div_pattern_o(pattern), .charge_pump_current_o(icp),
    .ref_clock_select_o(refsel), .vco_overvoltage_guard_o(ovp),
    .bandgap_clock_gate_o(gbg), .adc_clock_gate_o(gadc),
    .dac_clock_gate_o(gdac), .comparator_clock_gate_o(gcmp)
  );

  // Port views laid out like the register words
  assign pll_view  = {2'h0, vcox2, 19'h0_0000, modulo, pattern, 1'b0, icp,
                      refsel, ovp};
  assign gate_view = {27'h000_0000, gbg, gadc, 1'b0, gdac, gcmp};

  // Routing must hold steady while both sources agree
  always @(negedge clock) begin
    if (watch && irq !== 25'h1ff_ffff) begin
      glitches++;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 40) begin
      num_errors++;
      $display("ERROR %0t: bus wait timed out", $time);
      report_and_stop();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    int   n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    while (!(aw_done && w_done)) begin
      tick(n);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) begin
      tick(n);
    end
    // Late ready: the response must stand until it is taken
    if (lag > 0) begin
      repeat (lag) tick(n);
      check(bvalid, 1'b1);
      bready <= 1'b1;
      tick(n);
    end
    check(bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    if (lag > 0) begin
      repeat (lag) tick(n);
      check(rvalid, 1'b1);
      rready <= 1'b1;
      tick(n);
    end
    check(rdata, ed);
    check(rresp, er);
  endtask

  function automatic logic [24:0] route(input logic [24:0] s,
                                        input logic [49:0] g);
    for (int k = 0; k < 25; k++) begin
      route[k] = s[k] ? g[2*k] : g[2*k+1];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    gpio <= 50'h2_5a3c_96f0_0fe1;
    @(posedge clock);
    check(pll_view, 32'h2000_0002);
    check(gate_view, 32'h0000_001b);
    check(irq, route(25'h000_0000, gpio));
    axi_rd(pirpg_pkg::OFF_SEL, 32'h0000_0000, 2'h0);
    axi_rd(pirpg_pkg::OFF_PLL, 32'h2000_cc12, 2'h0);
    axi_rd(pirpg_pkg::OFF_GATES, 32'h0000_001b, 2'h0);
    foreach (sels[i]) begin
      axi_wr(pirpg_pkg::OFF_SEL, {7'h00, sels[i]}, 4'hf, 2'h0);
      @(posedge clock);
      check(irq, route(sels[i], gpio));
      gpio <= {gpio[48:0], gpio[49]};
      @(posedge clock);
      check(irq, route(sels[i], gpio));
      axi_rd(pirpg_pkg::OFF_SEL, {7'h00, sels[i]}, 2'h0);
    end
    gpio <= 50'h3_ffff_ffff_ffff;
    watch <= 1'b1;
    axi_wr(pirpg_pkg::OFF_SEL, 32'h0000_0000, 4'hf, 2'h0);
    axi_wr(pirpg_pkg::OFF_SEL, 32'h01ff_ffff, 4'hf, 2'h0);
    watch <= 1'b0;
    check(glitches, 32'h0000_0000);
    foreach (regs[i]) begin
      axi_wr(regs[i][39:32], regs[i][31:0], 4'hf, 2'h0);
      @(posedge clock);
      if (regs[i][39:32] == pirpg_pkg::OFF_PLL) begin
        check(pll_view, regs[i][31:0] & 32'h2000_03ef);
      end else begin
        check(gate_view, regs[i][31:0]);
      end
      axi_rd(regs[i][39:32], regs[i][31:0], 2'h0);
    end
    axi_wr(pirpg_pkg::OFF_PLL, 32'h0000_0000, 4'h2, 2'h0);
    axi_rd(pirpg_pkg::OFF_PLL, 32'h20ff_00ff, 2'h0);
    check(pll_view, 32'h2000_00ef);
    lag = 3;
    axi_wr(8'hbc, 32'h0000_0001, 4'hf, 2'h2);
    axi_rd(8'hbc, 32'h0000_0000, 2'h2);
    axi_rd(8'hac, 32'h0000_0000, 2'h2);
    axi_rd(pirpg_pkg::OFF_GATES, 32'h0000_001b, 2'h0);
    axi_wr(pirpg_pkg::OFF_GATES, 32'h0000_0000, 4'hf, 2'h0);
    check(gate_view, 32'h0000_0000);
    lag = 0;
    // Reset in mid-run must restore every field
    reset_n <= 1'b0;
    gpio <= 50'h2_5a3c_96f0_0fe1;
    repeat (2) @(posedge clock);
    check(pll_view, 32'h2000_0002);
    check(gate_view, 32'h0000_001b);
    reset_n <= 1'b1;
    @(posedge clock);
    check(irq, route(25'h000_0000, gpio));
    axi_rd(pirpg_pkg::OFF_SEL, 32'h0000_0000, 2'h0);
    axi_rd(pirpg_pkg::OFF_PLL, 32'h2000_cc12, 2'h0);
    report_and_stop();
  end
endmodule
